// ---- logic/basic_clock_divider_select_defines.svh ----
`ifndef BASIC_CLOCK_DIVIDER_SELECT_DEFINES_SVH
`define BASIC_CLOCK_DIVIDER_SELECT_DEFINES_SVH

// Converter control word layout and reset value
`define BASIC_CLOCK_DIVIDER_SELECT_DIV_HI      15
`define BASIC_CLOCK_DIVIDER_SELECT_DIV_LO      14
`define BASIC_CLOCK_DIVIDER_SELECT_STC_HI      13
`define BASIC_CLOCK_DIVIDER_SELECT_STC_LO      12
`define BASIC_CLOCK_DIVIDER_SELECT_CTRL_RESET  16'h0000

// Basic-clock division ratios per divider select code
`define BASIC_CLOCK_DIVIDER_SELECT_DIV_00      5'h04
`define BASIC_CLOCK_DIVIDER_SELECT_DIV_01      5'h02
`define BASIC_CLOCK_DIVIDER_SELECT_DIV_10      5'h10
`define BASIC_CLOCK_DIVIDER_SELECT_DIV_11      5'h08

// Sample length in basic-clock periods per sample-time select code
`define BASIC_CLOCK_DIVIDER_SELECT_STC_00      7'h08
`define BASIC_CLOCK_DIVIDER_SELECT_STC_01      7'h10
`define BASIC_CLOCK_DIVIDER_SELECT_STC_10      7'h20
`define BASIC_CLOCK_DIVIDER_SELECT_STC_11      7'h40

// Result determination in basic-clock periods, result load in CPU clocks
`define BASIC_CLOCK_DIVIDER_SELECT_RESOLVE_BC  7'h28
`define BASIC_CLOCK_DIVIDER_SELECT_LOAD_CPU    2'h2

// Calibration length after reset in basic-clock periods
`define BASIC_CLOCK_DIVIDER_SELECT_CAL_BC      12'hd00

// Full-scale result code
`define BASIC_CLOCK_DIVIDER_SELECT_RESULT_MAX  10'h3ff

`endif

// ---- logic/basic_clock_divider_select_pkg.sv ----
`include "basic_clock_divider_select_defines.svh"

package basic_clock_divider_select_pkg;

  // Conversion sequencer states
  typedef enum logic [1:0] {
    BASIC_CLOCK_DIVIDER_SELECT_IDLE    = 2'b00,
    BASIC_CLOCK_DIVIDER_SELECT_SAMPLE  = 2'b01,
    BASIC_CLOCK_DIVIDER_SELECT_RESOLVE = 2'b10,
    BASIC_CLOCK_DIVIDER_SELECT_LOAD    = 2'b11
  } basic_clock_divider_select_state_t;

  // State of the timing controller apart from the basic-clock prescaler count
  typedef struct packed {
    basic_clock_divider_select_state_t  st;
    logic [15:0]   ctrl;
    logic [1:0]    act_div;
    logic [1:0]    act_stc;
    logic [6:0]    bc_cnt;
    logic [1:0]    load_cnt;
    logic [11:0]   cal_cnt;
    logic          cal_busy;
    logic [9:0]    held;
    logic [9:0]    result;
    logic          result_valid;
  } basic_clock_divider_select_main_t;

  // State of the basic-clock prescaler
  typedef struct packed {
    logic [4:0] cnt;
  } basic_clock_divider_select_div_t;

  // Division ratio of the CPU clock for a divider select code
  function automatic logic [4:0] basic_clock_divider_select_div_ratio(input logic [1:0] sel);
    logic [4:0] r;
    r = `BASIC_CLOCK_DIVIDER_SELECT_DIV_00;
    unique case (sel)
      2'b00: r = `BASIC_CLOCK_DIVIDER_SELECT_DIV_00;
      2'b01: r = `BASIC_CLOCK_DIVIDER_SELECT_DIV_01;
      2'b10: r = `BASIC_CLOCK_DIVIDER_SELECT_DIV_10;
      2'b11: r = `BASIC_CLOCK_DIVIDER_SELECT_DIV_11;
    endcase
    return r;
  endfunction

  // Sample length in basic-clock periods for a sample-time select code
  function automatic logic [6:0] basic_clock_divider_select_sample_len(input logic [1:0] sel);
    logic [6:0] r;
    r = `BASIC_CLOCK_DIVIDER_SELECT_STC_00;
    unique case (sel)
      2'b00: r = `BASIC_CLOCK_DIVIDER_SELECT_STC_00;
      2'b01: r = `BASIC_CLOCK_DIVIDER_SELECT_STC_01;
      2'b10: r = `BASIC_CLOCK_DIVIDER_SELECT_STC_10;
      2'b11: r = `BASIC_CLOCK_DIVIDER_SELECT_STC_11;
    endcase
    return r;
  endfunction

  // Whole conversion length in CPU clocks
  function automatic logic [11:0] basic_clock_divider_select_conv_cycles(input logic [1:0] div, input logic [1:0] stc);
    logic [11:0] bc;
    logic [11:0] prod;
    bc   = {5'h00, basic_clock_divider_select_sample_len(stc)} + {5'h00, `BASIC_CLOCK_DIVIDER_SELECT_RESOLVE_BC};
    prod = 12'(bc * {7'h00, basic_clock_divider_select_div_ratio(div)});
    return prod + {10'h000, `BASIC_CLOCK_DIVIDER_SELECT_LOAD_CPU};
  endfunction

endpackage

// ---- logic/basic_clock_divider_select_clkdiv.sv ----
`timescale 1ns/1ps
`include "basic_clock_divider_select_defines.svh"

module basic_clock_divider_select_clkdiv
  import basic_clock_divider_select_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic [1:0] div_sel,
  input  wire logic       restart,
  output logic            tick
);

  basic_clock_divider_select_div_t s_r;
  basic_clock_divider_select_div_t s_nxt;
  logic [4:0] last;

  // One tick per basic-clock period; at-or-above compare survives a ratio drop
  assign last = basic_clock_divider_select_div_ratio(div_sel) - 5'h01;
  assign tick = (s_r.cnt >= last);

  // Prescaler count, realigned when a conversion starts
  always_comb
  begin
    s_nxt = s_r;
    if (restart || tick)
    begin
      s_nxt.cnt = 5'h00;
    end
    else
    begin
      s_nxt.cnt = s_r.cnt + 5'h01;
    end
  end

  // State register
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

endmodule

// ---- logic/basic_clock_divider_select_timing.sv ----
// Function
// - Divider code 00/01/10/11 divides CPU clock by 4/2/16/8 for basic clock.
// - Sample code 00/01/10/11 gives 8/16/32/64 basic-clock periods of sampling.
// - Conversion equals sample time plus 40 basic periods plus 2 CPU clocks.
// - Calibration after reset takes at least 3328 basic-clock periods.
// - Divider code resets to divide-by-four.
// - Conversions run during calibration and stretch its total duration.
// - Input below ground gives zero, above reference gives all ones.
// - Input is captured only while sampling; later changes have no effect.
`timescale 1ns/1ps
`include "basic_clock_divider_select_defines.svh"

module basic_clock_divider_select_timing
  import basic_clock_divider_select_pkg::*;
#(
  parameter int AIN_W = 12
)
(
  input  wire logic                     mclk,
  input  wire logic                     resetn,
  input  wire logic                     ctrl_wr,
  input  wire logic [15:0]              ctrl_wdata,
  output logic      [15:0]              converter_control_register,
  input  wire logic                     conv_req,
  output logic                          conv_ready,
  input  wire logic signed [AIN_W-1:0]  ain_level,
  output logic                          sampling,
  output logic                          conv_busy,
  output logic                          cal_busy,
  output logic      [9:0]               result,
  output logic                          result_valid
);

  localparam logic signed [AIN_W-1:0] AIN_TOP = AIN_W'(`BASIC_CLOCK_DIVIDER_SELECT_RESULT_MAX);

  basic_clock_divider_select_main_t s_r;
  basic_clock_divider_select_main_t s_nxt;
  logic        tick;
  logic        accept;
  logic [1:0]  div_sel;
  logic [9:0]  clamped;
  logic [1:0]  basic_clock_divider_select;
  logic [1:0]  sample_time_select;

  // Control fields of the programmed word
  assign basic_clock_divider_select = s_r.ctrl[`BASIC_CLOCK_DIVIDER_SELECT_DIV_HI:`BASIC_CLOCK_DIVIDER_SELECT_DIV_LO];
  assign sample_time_select         = s_r.ctrl[`BASIC_CLOCK_DIVIDER_SELECT_STC_HI:`BASIC_CLOCK_DIVIDER_SELECT_STC_LO];

  // Idle follows the programmed divider, a conversion keeps its latched one
  assign accept  = (s_r.st == BASIC_CLOCK_DIVIDER_SELECT_IDLE) && conv_req;
  assign div_sel = (s_r.st == BASIC_CLOCK_DIVIDER_SELECT_IDLE) ? basic_clock_divider_select : s_r.act_div;

  // Basic-clock prescaler
  basic_clock_divider_select_clkdiv u_clkdiv (
    .mclk    (mclk),
    .resetn  (resetn),
    .div_sel (div_sel),
    .restart (accept),
    .tick    (tick)
  );

  // Saturate out-of-range inputs to the code limits
  always_comb
  begin
    if (ain_level < 0)
    begin
      clamped = 10'h000;
    end
    else if (ain_level > AIN_TOP)
    begin
      clamped = `BASIC_CLOCK_DIVIDER_SELECT_RESULT_MAX;
    end
    else
    begin
      clamped = ain_level[9:0];
    end
  end

  // Sequencer, control word and calibration
  always_comb
  begin
    s_nxt              = s_r;
    s_nxt.result_valid = 1'b0;
    if (ctrl_wr)
    begin
      s_nxt.ctrl = ctrl_wdata;
    end
    unique case (s_r.st)
      BASIC_CLOCK_DIVIDER_SELECT_IDLE:
      begin
        if (conv_req)
        begin
          s_nxt.st      = BASIC_CLOCK_DIVIDER_SELECT_SAMPLE;
          s_nxt.act_div = basic_clock_divider_select;
          s_nxt.act_stc = sample_time_select;
          s_nxt.bc_cnt  = 7'h00;
        end
      end
      BASIC_CLOCK_DIVIDER_SELECT_SAMPLE:
      begin
        s_nxt.held = clamped;
        if (tick)
        begin
          if (s_r.bc_cnt == basic_clock_divider_select_sample_len(s_r.act_stc) - 7'h01)
          begin
            s_nxt.st     = BASIC_CLOCK_DIVIDER_SELECT_RESOLVE;
            s_nxt.bc_cnt = 7'h00;
          end
          else
          begin
            s_nxt.bc_cnt = s_r.bc_cnt + 7'h01;
          end
        end
      end
      BASIC_CLOCK_DIVIDER_SELECT_RESOLVE:
      begin
        if (tick)
        begin
          if (s_r.bc_cnt == `BASIC_CLOCK_DIVIDER_SELECT_RESOLVE_BC - 7'h01)
          begin
            s_nxt.st       = BASIC_CLOCK_DIVIDER_SELECT_LOAD;
            s_nxt.load_cnt = 2'h0;
          end
          else
          begin
            s_nxt.bc_cnt = s_r.bc_cnt + 7'h01;
          end
        end
      end
      BASIC_CLOCK_DIVIDER_SELECT_LOAD:
      begin
        if (s_r.load_cnt == `BASIC_CLOCK_DIVIDER_SELECT_LOAD_CPU - 2'h1)
        begin
          s_nxt.st           = BASIC_CLOCK_DIVIDER_SELECT_IDLE;
          s_nxt.result       = s_r.held;
          s_nxt.result_valid = 1'b1;
        end
        else
        begin
          s_nxt.load_cnt = s_r.load_cnt + 2'h1;
        end
      end
    endcase
    // Calibration advances only between conversions
    if (s_r.cal_busy && (s_r.st == BASIC_CLOCK_DIVIDER_SELECT_IDLE) && tick)
    begin
      if (s_r.cal_cnt == `BASIC_CLOCK_DIVIDER_SELECT_CAL_BC - 12'h001)
      begin
        s_nxt.cal_busy = 1'b0;
      end
      else
      begin
        s_nxt.cal_cnt = s_r.cal_cnt + 12'h001;
      end
    end
  end

  // State register; reset starts calibration with divide-by-four
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      s_r <= '{st: BASIC_CLOCK_DIVIDER_SELECT_IDLE, ctrl: `BASIC_CLOCK_DIVIDER_SELECT_CTRL_RESET, cal_busy: 1'b1, default: '0};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // Outputs
  assign converter_control_register = s_r.ctrl;
  assign conv_ready                 = (s_r.st == BASIC_CLOCK_DIVIDER_SELECT_IDLE);
  assign sampling                   = (s_r.st == BASIC_CLOCK_DIVIDER_SELECT_SAMPLE);
  assign conv_busy                  = (s_r.st != BASIC_CLOCK_DIVIDER_SELECT_IDLE);
  assign cal_busy                   = s_r.cal_busy;
  assign result                     = s_r.result;
  assign result_valid               = s_r.result_valid;

  // Checking helpers: cycles since tick, conversion length, calibration ticks
  logic [4:0]  gap_r;
  logic [11:0] cyc_r;
  logic [11:0] caltick_r;

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      gap_r     <= 5'h00;
      cyc_r     <= 12'h000;
      caltick_r <= 12'h000;
    end
    else
    begin
      gap_r     <= (accept || tick) ? 5'h00 : gap_r + 5'h01;
      cyc_r     <= accept ? 12'h000 : (conv_busy ? cyc_r + 12'h001 : cyc_r);
      caltick_r <= (cal_busy && conv_ready && tick) ? caltick_r + 12'h001 : caltick_r;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking

  default disable iff (!resetn);

  sequence seq_load_run;
    (s_r.st == BASIC_CLOCK_DIVIDER_SELECT_LOAD) [*2];
  endsequence

  sequence seq_result_out;
    conv_ready && result_valid && (result == $past(s_r.held));
  endsequence

  div_reset_a: assert property (disable iff (1'b0) !resetn |=> basic_clock_divider_select == 2'b00)
    else $error("divider select not cleared by reset");
  tick_period_a: assert property ((tick && conv_busy) |-> gap_r == basic_clock_divider_select_div_ratio(s_r.act_div) - 5'h01)
    else $error("basic clock period wrong");
  conv_time_a: assert property (result_valid |-> cyc_r == basic_clock_divider_select_conv_cycles(s_r.act_div, s_r.act_stc))
    else $error("conversion length wrong");
  load_phase_a: assert property ($rose(s_r.st == BASIC_CLOCK_DIVIDER_SELECT_LOAD) |-> seq_load_run ##1 seq_result_out)
    else $error("result load phase wrong");
  sample_len_a: assert property (($fell(sampling) && conv_busy) |->
                                 cyc_r == 12'(basic_clock_divider_select_sample_len(s_r.act_stc) * basic_clock_divider_select_div_ratio(s_r.act_div)))
    else $error("sample length wrong");
  cal_len_a: assert property ($fell(cal_busy) |-> caltick_r == `BASIC_CLOCK_DIVIDER_SELECT_CAL_BC)
    else $error("calibration length wrong");
  cal_request_a: assert property ((cal_busy && accept) |=> sampling && cal_busy)
    else $error("request refused or calibration ended during conversion");
  clamp_low_a: assert property ((sampling && ain_level < 0) |=> s_r.held == 10'h000)
    else $error("low input not clamped");
  clamp_high_a: assert property ((sampling && ain_level > AIN_TOP) |=> s_r.held == `BASIC_CLOCK_DIVIDER_SELECT_RESULT_MAX)
    else $error("high input not clamped");
  hold_freeze_a: assert property ((conv_busy && !sampling) |=> $stable(s_r.held))
    else $error("held sample changed after sampling");
  settings_hold_a: assert property ((conv_busy && $past(conv_busy)) |->
                                    $stable(s_r.act_div) && $stable(s_r.act_stc))
    else $error("settings changed mid conversion");

endmodule

// ---- bench/basic_clock_divider_select_tb.sv ----
`timescale 1ns/1ps

module tb;
  logic               mclk        = 1'b0;
  logic               resetn      = 1'b0;
  logic               ctrl_wr     = 1'b0;
  logic [15:0]        ctrl_wdata  = 16'h0000;
  logic               conv_req    = 1'b0;
  logic signed [11:0] ain_level   = 12'sh000;
  logic [15:0]        converter_control_register;
  logic               conv_ready;
  logic               sampling;
  logic               conv_busy;
  logic               cal_busy;
  logic [9:0]         result;
  logic               result_valid;
  int                 failures    = 0;
  int                 checks      = 0;
  int                 dtab[4]     = '{4, 2, 16, 8};
  int                 ntab[4]     = '{8, 16, 32, 64};

  // Device under test
  basic_clock_divider_select_timing #(.AIN_W(12)) basic_clock_divider_select_timing_inst (
    .mclk                       (mclk),
    .resetn                     (resetn),
    .ctrl_wr                    (ctrl_wr),
    .ctrl_wdata                 (ctrl_wdata),
    .converter_control_register (converter_control_register),
    .conv_req                   (conv_req),
    .conv_ready                 (conv_ready),
    .ain_level                  (ain_level),
    .sampling                   (sampling),
    .conv_busy                  (conv_busy),
    .cal_busy                   (cal_busy),
    .result                     (result),
    .result_valid               (result_valid)
  );

  // Free-running 100 MHz clock
  always #5 mclk = ~mclk;

  // Compare seen against expected and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Print counts and verdict, then stop
  task automatic give_verdict;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Hold reset low for 16 cycles, release on the last edge
  task automatic do_reset;
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
  endtask

  // Program the control word, run one conversion and judge length and result
  task automatic run_conv(input logic [15:0] cw, input logic signed [11:0] a0, input logic signed [11:0] a1,
                          input logic mid, input logic [15:0] mw, input logic [9:0] er);
    int n;
    int s;
    int sd;
    int tt;
    sd = ntab[cw[13:12]] * dtab[cw[15:14]];
    tt = (ntab[cw[13:12]] + 40) * dtab[cw[15:14]] + 2;
    n = 0;
    s = 0;
    @(posedge mclk);
    ctrl_wr <= 1'b1;
    ctrl_wdata <= cw;
    ain_level <= a0;
    @(posedge mclk);
    ctrl_wr <= 1'b0;
    conv_req <= 1'b1;
    #1;
    check(converter_control_register, cw);
    check(conv_ready, 1'b1);
    @(posedge mclk);
    conv_req <= 1'b0;
    // First sample cycle follows the accept edge directly
    #1;
    if (sampling === 1'b1)
      s++;
    while (n < 2000 && result_valid !== 1'b1)
    begin
      @(posedge mclk);
      n++;
      // Input moves once the sample window has closed
      if (n == sd)
        ain_level <= a1;
      // Optional control write and stray request while busy
      if (mid && n == 5)
      begin
        ctrl_wr <= 1'b1;
        ctrl_wdata <= mw;
        conv_req <= 1'b1;
      end
      if (n == 6)
      begin
        ctrl_wr <= 1'b0;
        conv_req <= 1'b0;
      end
      #1;
      if (sampling === 1'b1)
        s++;
    end
    check(n, tt);
    check(s, sd);
    check(result, er);
    if (mid)
      check(converter_control_register, mw);
  endtask

  // Every divider and sample-time code pair
  task automatic test_timing;
    for (int d = 0; d < 4; d++)
      for (int t = 0; t < 4; t++)
        run_conv({2'(d), 2'(t), 12'h0a5}, 12'(100 + d * 4 + t), 12'(100 + d * 4 + t), 1'b0, 16'h0000,
                 10'(100 + d * 4 + t));
    $display("test timing done");
  endtask

  // Out-of-range inputs saturate, in-range edges pass
  task automatic test_clamp;
    run_conv(16'h4000, -12'sh005, -12'sh005, 1'b0, 16'h0000, 10'h000);
    run_conv(16'h4000, 12'sh000, 12'sh000, 1'b0, 16'h0000, 10'h000);
    run_conv(16'h4000, 12'sh3ff, 12'sh3ff, 1'b0, 16'h0000, 10'h3ff);
    run_conv(16'h4000, 12'sh7d0, 12'sh7d0, 1'b0, 16'h0000, 10'h3ff);
    $display("test clamp done");
  endtask

  // Late input changes and mid-conversion writes leave the result alone
  task automatic test_capture;
    // Divide by sixteen keeps the basic clock inside its legal band at 100 MHz
    run_conv(16'h8000, 12'sh064, 12'sh384, 1'b0, 16'h0000, 10'h064);
    run_conv(16'h8000, 12'sh384, -12'sh001, 1'b0, 16'h0000, 10'h384);
    run_conv(16'h4000, 12'sh032, 12'sh032, 1'b1, 16'hf000, 10'h032);
    $display("test capture done");
  endtask

  // Reset values, then calibration length with or without a conversion inside
  task automatic test_cal(input logic with_conv, input int lo, input int hi);
    longint t0;
    int n;
    do_reset();
    #1;
    check(converter_control_register, 16'h0000);
    check(cal_busy, 1'b1);
    check(result, 10'h000);
    check(result_valid, 1'b0);
    check(conv_ready, 1'b1);
    check(conv_busy, 1'b0);
    check(sampling, 1'b0);
    t0 = $time;
    if (with_conv)
    begin
      repeat (100) @(posedge mclk);
      // Divider is programmed well inside the early window after reset
      run_conv(16'h0000, 12'sh007, 12'sh007, 1'b0, 16'h0000, 10'h007);
      check(cal_busy, 1'b1);
    end
    while (cal_busy !== 1'b0 && ($time - t0) < 200000)
    begin
      @(posedge mclk);
      #1;
    end
    n = int'(($time - t0) / 10);
    check(n >= lo && n <= hi, 1'b1);
    $display("test calibration done");
  endtask

  // Main sequence
  initial
  begin
    do_reset();
    test_timing();
    test_clamp();
    test_capture();
    test_cal(1'b0, 13312, 13314);
    test_cal(1'b1, 13506, 13518);
    give_verdict();
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    #1000000;
    failures++;
    give_verdict();
  end
endmodule
